// File: sramc_ctrl.sv
/*
 * host-side controller for an 8192 x 8 asynchronous static memory.
 * user side: one request at a time, taken when ready is high.
 * pin side: registered address, selects, strobes and a split data bus;
 * the surrounding pad logic merges dq out/in/oe into the real wire.
 */
`timescale 1ns/1ps
module sramc_ctrl #(
	parameter int ADDR_W = sramc_pkg::ADDR_W,
	parameter int DATA_W = sramc_pkg::DATA_W
) (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// user request side
	input wire logic REQ_VALID_I,
	input wire sramc_pkg::sramc_req_t REQ_I,
	output logic REQ_READY_O,
	output logic RD_VALID_O,
	output logic [DATA_W-1:0] RD_DATA_O,
	// memory pins
	output logic [ADDR_W-1:0] SRAM_ADDR_O,
	output logic SRAM_SEL_LOW_N_O,
	output logic SRAM_SEL_HIGH_O,
	output logic SRAM_WE_N_O,
	output logic SRAM_OE_N_O,
	output logic [DATA_W-1:0] SRAM_DQ_O,
	output logic SRAM_DQ_OE_O,
	input wire logic [DATA_W-1:0] SRAM_DQ_I
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the memory geometry is fixed, so other widths are refused up front
	if (ADDR_W != sramc_pkg::ADDR_W) begin : g_bad_addr_w // [R1]
		$error("address width must match the memory");
	end
	if (DATA_W != sramc_pkg::DATA_W) begin : g_bad_data_w // [R1]
		$error("data width must match the memory");
	end

	localparam int RD_LO = sramc_pkg::RD_CYC;
	localparam int RD_HI = sramc_pkg::RD_CYC + 2;

	sramc_pkg::sramc_state_t state_ff;
	sramc_pkg::sramc_state_t nxt_state;
	sramc_pkg::sramc_req_t req_ff;
	sramc_pkg::sramc_pins_t pins_ff;
	logic ready_ff;
	logic rd_valid_ff;
	logic [DATA_W-1:0] rd_data_ff;
	logic accept;
	logic tmr_start;
	logic [sramc_pkg::TMR_W-1:0] tmr_len;
	logic tmr_done;
	logic nxt_sel;
	logic nxt_we;

	assign accept = ready_ff && REQ_VALID_I;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	// next state; idle leaves the memory deselected and the bus free
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			sramc_pkg::ST_IDLE: begin
				if (accept) begin
					nxt_state = REQ_I.wr ? sramc_pkg::ST_WR_SETUP : sramc_pkg::ST_RD_WAIT;
				end
			end
			sramc_pkg::ST_RD_WAIT: begin
				if (tmr_done) nxt_state = sramc_pkg::ST_RD_RECOVER;
			end
			sramc_pkg::ST_RD_RECOVER: begin
				if (tmr_done) nxt_state = sramc_pkg::ST_IDLE;
			end
			sramc_pkg::ST_WR_SETUP: begin
				nxt_state = sramc_pkg::ST_WR_PULSE;
			end
			sramc_pkg::ST_WR_PULSE: begin
				if (tmr_done) nxt_state = sramc_pkg::ST_WR_HOLD;
			end
			sramc_pkg::ST_WR_HOLD: begin
				nxt_state = sramc_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = sramc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_ff <= sramc_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// timer start on entry to every timed state
	always_comb begin
		tmr_start = 1'b0;
		tmr_len = sramc_pkg::TMR_W'(sramc_pkg::RD_CYC);
		if (nxt_state != state_ff) begin
			case (nxt_state)
				sramc_pkg::ST_RD_WAIT: begin
					tmr_start = 1'b1;
					tmr_len = sramc_pkg::TMR_W'(sramc_pkg::RD_CYC);
				end
				sramc_pkg::ST_RD_RECOVER: begin
					tmr_start = 1'b1;
					tmr_len = sramc_pkg::TMR_W'(sramc_pkg::HZ_CYC);
				end
				sramc_pkg::ST_WR_PULSE: begin
					tmr_start = 1'b1;
					tmr_len = sramc_pkg::TMR_W'(sramc_pkg::WR_CYC);
				end
				default: begin
					tmr_start = 1'b0;
				end
			endcase
		end
	end

	sramc_timer #(
		.W(sramc_pkg::TMR_W)
	) u_timer (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.start_i(tmr_start),
		.len_i(tmr_len),
		.done_o(tmr_done)
	);

	// ----------------------------------------------------------------
	// user side
	// ----------------------------------------------------------------
	// request held for the whole access, so pins never glitch mid-cycle
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			req_ff <= '0;
		end else if (accept) begin
			req_ff <= REQ_I;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= (nxt_state == sramc_pkg::ST_IDLE);
		end
	end

	// read data sampled on the edge that ends the access window
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rd_valid_ff <= 1'b0;
			rd_data_ff <= '0;
		end else begin
			rd_valid_ff <= 1'b0;
			if (state_ff == sramc_pkg::ST_RD_WAIT && tmr_done) begin
				rd_valid_ff <= 1'b1;
				rd_data_ff <= SRAM_DQ_I; // [R3]
			end
		end
	end

	// ----------------------------------------------------------------
	// pin side
	// ----------------------------------------------------------------
	// in strobe mode the selects frame setup and hold and the strobe makes
	// the window; in select mode the roles swap, so either signal can open
	// and close the write
	always_comb begin
		nxt_sel = 1'b0;
		nxt_we = 1'b0;
		case (nxt_state)
			sramc_pkg::ST_RD_WAIT: begin
				nxt_sel = 1'b1; // [R3]
			end
			sramc_pkg::ST_WR_PULSE: begin
				nxt_sel = 1'b1; // [R2] [R6]
				nxt_we = 1'b1;
			end
			sramc_pkg::ST_WR_SETUP, sramc_pkg::ST_WR_HOLD: begin
				nxt_sel = (req_ff.wmode == sramc_pkg::WMODE_STROBE); // [R6]
				nxt_we = (req_ff.wmode == sramc_pkg::WMODE_SELECT);
			end
			default: begin
				nxt_sel = 1'b0; // [R4]
			end
		endcase
		if (accept) begin
			nxt_sel = !REQ_I.wr || (REQ_I.wmode == sramc_pkg::WMODE_STROBE);
			nxt_we = REQ_I.wr && (REQ_I.wmode == sramc_pkg::WMODE_SELECT);
		end
	end

	// address moves only on accept, together with or before the selects
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pins_ff.addr <= '0;
			pins_ff.dq <= '0;
		end else if (accept) begin
			pins_ff.addr <= REQ_I.addr; // [R8]
			pins_ff.dq <= REQ_I.data;
		end
	end

	// selects, strobes and bus drive; enable stays high through writes
	// so the memory never fights the write data
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pins_ff.sel_low_n <= sramc_pkg::PIN_SEL_LOW_N_RST;
			pins_ff.sel_high <= sramc_pkg::PIN_SEL_HIGH_RST;
			pins_ff.we_n <= sramc_pkg::PIN_WE_N_RST;
			pins_ff.oe_n <= sramc_pkg::PIN_OE_N_RST;
			pins_ff.dq_oe <= 1'b0;
		end else begin
			pins_ff.sel_low_n <= !nxt_sel;
			pins_ff.sel_high <= nxt_sel;
			pins_ff.we_n <= !nxt_we; // [R2]
			pins_ff.oe_n <= (nxt_state != sramc_pkg::ST_RD_WAIT); // [R3]
			pins_ff.dq_oe <= nxt_state == sramc_pkg::ST_WR_SETUP ||
				nxt_state == sramc_pkg::ST_WR_PULSE ||
				nxt_state == sramc_pkg::ST_WR_HOLD; // [R2]
		end
	end

	assign REQ_READY_O = ready_ff;
	assign RD_VALID_O = rd_valid_ff;
	assign RD_DATA_O = rd_data_ff;
	assign SRAM_ADDR_O = pins_ff.addr;
	assign SRAM_SEL_LOW_N_O = pins_ff.sel_low_n;
	assign SRAM_SEL_HIGH_O = pins_ff.sel_high;
	assign SRAM_WE_N_O = pins_ff.we_n;
	assign SRAM_OE_N_O = pins_ff.oe_n;
	assign SRAM_DQ_O = pins_ff.dq;
	assign SRAM_DQ_OE_O = pins_ff.dq_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic sel_on;
	logic win_on;
	assign sel_on = !pins_ff.sel_low_n && pins_ff.sel_high;
	assign win_on = sel_on && !pins_ff.we_n;

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	write_bus_a: assert property (win_on |-> pins_ff.oe_n && pins_ff.dq_oe) // [R2]
		else $error("write window without data drive or with enable low");

	read_drive_a: assert property (!pins_ff.oe_n |-> sel_on && pins_ff.we_n && !pins_ff.dq_oe) // [R3]
		else $error("read enable outside a clean read");

	read_data_a: assert property ($fell(pins_ff.oe_n) |-> ##[RD_LO:RD_HI] rd_valid_ff) // [R3]
		else $error("read data not returned in time");

	win_stable_a: assert property (win_on && $past(win_on) |->
		$stable(pins_ff.addr) && $stable(pins_ff.dq)) // [R6]
		else $error("address or data moved inside write window");

	win_close_a: assert property ($fell(win_on) |-> pins_ff.dq_oe && $stable(pins_ff.addr)) // [R6]
		else $error("data released before write window closed");

	addr_hold_a: assert property (sel_on && $past(sel_on) |-> $stable(pins_ff.addr)) // [R8]
		else $error("address changed while selected");

	idle_quiet_a: assert property (ready_ff |-> !sel_on && !pins_ff.dq_oe && pins_ff.oe_n) // [R4]
		else $error("memory not in standby while idle");

endmodule : sramc_ctrl

// File: sramc_mem_model.sv
/*
 * behavioural 8192 x 8 static memory that answers the controller's pins.
 * assumes the bench merges its data output with the controller's drive.
 */
`timescale 1ns/1ps
module sramc_mem_model (
	input wire logic [12:0] addr_i,
	input wire logic sel_low_n_i,
	input wire logic sel_high_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o
);
	// ----------------------------------------
	// storage and pin decode
	// ----------------------------------------
	logic [7:0] mem [8192];
	logic sel;
	logic win;
	logic rd;
	logic [12:0] wa;
	logic [7:0] wd;
	// either select inactive means standby
	assign sel = !sel_low_n_i && sel_high_i;
	assign win = sel && !we_n_i;
	assign rd = sel && we_n_i && !oe_n_i;
	// window tracks address and data, the byte lands at its close
	always @* if (win) begin
		wa = addr_i;
		wd = dq_i;
	end
	always @(negedge win) mem[wa] = wd;
	// released bus shows a changing wrong byte, never the stored one
	assign dq_o = rd ? mem[addr_i] : ~mem[addr_i];
endmodule : sramc_mem_model

// File: sramc_pkg.sv
/*
 * constants, types and timing counts for the host-side controller of an
 * 8192 x 8 asynchronous static memory with two selects of opposite polarity.
 * assumes a single 50 MHz clock; all pin timings are rounded to whole cycles.
 */
// Overview of operation
// R1: memory holds 8192 bytes, 13-bit address, shared bus
// R2: write while strobe, low select low, high select high
// R3: read drives data with output enable low, strobe high
// R4: either select inactive means standby, bus released
// R5: selected, strobe and enable high: bus stays released
// R6: write window spans overlap of select and strobe
// R7: continuous read gives new data per address
// R8: address valid no later than last select active
// R9: device commits byte when write window closes
package sramc_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int DEPTH = 8192;

	// ----------------------------------------------------------------
	// timing: figures in ns, counts in cycles of the 20 ns clock
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_AA_NS = 25;   // address and select access, slowest grade
	localparam int T_WP_NS = 20;   // write pulse, select to end, address to end
	localparam int T_HZOE_NS = 8;  // output release after enable goes high
	// least times round up
	localparam int RD_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HZ_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 4;

	// ----------------------------------------------------------------
	// reset values of the pins: deselected, strobes high, bus released
	// ----------------------------------------------------------------
	localparam logic PIN_SEL_LOW_N_RST = 1'h1;
	localparam logic PIN_SEL_HIGH_RST = 1'h0;
	localparam logic PIN_WE_N_RST = 1'h1;
	localparam logic PIN_OE_N_RST = 1'h1;

	// write control modes
	localparam logic WMODE_STROBE = 1'h0; // strobe opens and closes the window
	localparam logic WMODE_SELECT = 1'h1; // selects open and close the window

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RD_WAIT = 6'h02,
		ST_RD_RECOVER = 6'h04,
		ST_WR_SETUP = 6'h08,
		ST_WR_PULSE = 6'h10,
		ST_WR_HOLD = 6'h20
	} sramc_state_t;

	typedef struct packed {
		logic wr;
		logic wmode;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} sramc_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic sel_low_n;
		logic sel_high;
		logic we_n;
		logic oe_n;
		logic [DATA_W-1:0] dq;
		logic dq_oe;
	} sramc_pins_t;

endpackage : sramc_pkg

// File: sramc_timer.sv
/*
 * one-shot cycle timer: loaded with a length, it pulses done once the
 * length has run out.
 * assumes start is a single-cycle pulse and len_i is at least one.
 */
`timescale 1ns/1ps
module sramc_timer #(
	parameter int W = sramc_pkg::TMR_W
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [W-1:0] len_i,
	output logic done_o
);

	logic [W-1:0] cnt_ff;
	logic done_ff;

	// a one-bit counter cannot tell a length of two from idle
	if (W < 2) begin : g_bad_w
		$error("timer width too small");
	end

	// down counter, restarts on every start pulse
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else if (start_i) begin
			cnt_ff <= len_i;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	// done comes one edge after the count hits one, so a state lasts len+1
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= !start_i && (cnt_ff == W'(1));
		end
	end

	assign done_o = done_ff;

endmodule : sramc_timer

// File: tb_top.sv
/*
 * self-checking bench: controller against a behavioural memory.
 * assumes one clock, a five-cycle write and a six-cycle read in the controller.
 */
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic req_valid = 1'h0;
	sramc_pkg::sramc_req_t req = '0;
	logic ready, rd_valid, sel_n, sel_h, we_n, oe_n, dq_oe;
	logic [7:0] rd_data, dq_out, mem_dq, bus;
	logic [12:0] addr;
	logic [12:0] prev_addr = 13'h0;
	logic prev_sel = 1'h0;
	logic [7:0] shadow [8192];
	int errors = 0;
	int checked = 0;
	// clock of 20 ns; bus merge favours whoever drives
	always #10 ref_clk = ~ref_clk;
	assign bus = dq_oe ? dq_out : mem_dq;
	sramc_ctrl u_dut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .REQ_VALID_I(req_valid),
		.REQ_I(req), .REQ_READY_O(ready), .RD_VALID_O(rd_valid), .RD_DATA_O(rd_data),
		.SRAM_ADDR_O(addr), .SRAM_SEL_LOW_N_O(sel_n), .SRAM_SEL_HIGH_O(sel_h),
		.SRAM_WE_N_O(we_n), .SRAM_OE_N_O(oe_n), .SRAM_DQ_O(dq_out),
		.SRAM_DQ_OE_O(dq_oe), .SRAM_DQ_I(bus));
	sramc_mem_model u_mem (.addr_i(addr), .sel_low_n_i(sel_n), .sel_high_i(sel_h),
		.we_n_i(we_n), .oe_n_i(oe_n), .dq_i(bus), .dq_o(mem_dq));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// one access, judged cycle by cycle; hold keeps a refused write pending
	task automatic access(input logic wr, input logic wm, input logic [12:0] a,
		input logic [7:0] d, input logic hold);
		int n;
		logic on_we;
		logic on_sel;
		n = 0;
		while (ready !== 1'h1 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		req_valid = 1'h1;
		req = '{wr, wm, a, d};
		@(posedge ref_clk);
		if (wr) shadow[a] = d;
		for (int k = 1; k <= (wr ? 5 : 6); k++) begin
			@(negedge ref_clk);
			if (k == 1 && hold) req = '{1'h1, 1'h0, a, ~d};
			if (k == 4 || !hold) req_valid = 1'h0;
			on_we = wr && (wm ? k < 5 : (k == 2 || k == 3));
			on_sel = wr ? (wm ? (k == 2 || k == 3) : k < 5) : k < 4;
			check("write strobe", we_n, !on_we);
			check("selects", {sel_n, sel_h}, on_sel ? 2'h1 : 2'h2);
			check("output enable", oe_n, wr || k > 3);
			check("data drive", dq_oe, wr && k < 5);
			check("read valid", rd_valid, !wr && k == 4);
			check("ready", ready, wr ? k == 5 : k == 6);
			if (!wr && k == 4) check("read data", rd_data, shadow[a]);
		end
		check("ready back", ready, 1'h1);
	endtask : access
	// address held while selected, no drive against the memory
	always @(posedge ref_clk) if (rst_n) begin
		if (!sel_n && prev_sel) check("address held", addr, prev_addr);
		check("bus turn", !oe_n && dq_oe, 1'h0);
		prev_sel <= !sel_n;
		prev_addr <= addr;
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		repeat (8) @(negedge ref_clk);
		check("reset pins", {ready, rd_valid, sel_n, sel_h, we_n, oe_n, dq_oe}, 7'h16);
		$display("test reset done");
	endtask : t_reset
	// both write modes at the ends of the space, then back-to-back reads
	task automatic t_modes();
		logic [12:0] tbl [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 3; i++) access(1'h1, m[0], tbl[i], 8'h5A ^ 8'(i * 37 + m), 1'h0);
			for (int i = 0; i < 3; i++) access(1'h0, 1'h0, tbl[i], 8'h00, 1'h0);
		end
		$display("test modes done");
	endtask : t_modes
	// a write offered while busy must leave the byte untouched
	task automatic t_refused();
		access(1'h1, 1'h0, 13'h0123, 8'hC3, 1'h0);
		access(1'h0, 1'h0, 13'h0123, 8'hC3, 1'h1);
		access(1'h0, 1'h0, 13'h0123, 8'h00, 1'h0);
		$display("test refused done");
	endtask : t_refused
	initial begin
		t_reset();
		repeat (8) @(negedge ref_clk);
		rst_n = 1'h1;
		t_modes();
		t_refused();
		print_verdict();
	end
	// watchdog well beyond some fifteen accesses of 100 to 120 ns
	initial begin
		#100000;
		errors++;
		print_verdict();
	end
endmodule : tb_top
